// File: rtl/msp_serial_port.sv
// Multichannel buffered serial port with APB register access
// Overview of operation
// - Transmit and receive run as separate channels with own clock and frame sync.
// - Written transmit word moves to shift register; next word may be written meanwhile.
// - Received bits go shift register, buffer, data register when that is empty.
// - Transmit and receive timing travel on their own clock and frame sync pins.
// - Word length selectable as 8, 12, 16, 20, 24 or 32 bits.
// - Multichannel mode treats frames as TDM, 32 of up to 128 channels enabled.
// - Channel enables are chosen separately for transmitter and receiver.
// - Companding encodes transmit data by mu or A law, decodes receive data.
// - Frame width, period, delay, clock source and division are programmable.
// - Clock and frame sync polarities are each programmable.
// - Clock-stop mode joins transmitter and receiver as one SPI master or slave.
// - Internal bit clock at most half the bus clock; an external one needs each level held at least two bus cycles.
// - Interrupts, DMA events and status flags pace data register transfers.
`timescale 1ns/100ps
`include "msp_map.svh"
module msp_serial_port #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // APB slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input msp_pkg::msp_word_t pwdata,
  output msp_pkg::msp_word_t prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt and DMA events
  output logic irq,
  output logic tx_dma_req,
  output logic rx_dma_req,
  // Transmit pins
  input logic tx_bit_clock_pin,
  output logic tx_bit_clock_drv,
  output logic tx_bit_clock_oe,
  input logic tx_frame_sync_pin,
  output logic tx_frame_sync_drv,
  output logic tx_frame_sync_oe,
  output logic tx_serial_data,
  output logic tx_serial_data_oe,
  // Receive pins
  input logic rx_bit_clock_pin,
  output logic rx_bit_clock_drv,
  output logic rx_bit_clock_oe,
  input logic rx_frame_sync_pin,
  output logic rx_frame_sync_drv,
  output logic rx_frame_sync_oe,
  input logic rx_serial_data
);
  import msp_pkg::*;

  if (DIV_W < 1 || DIV_W > 8) begin : g_bad_div
    $error("DIV_W must lie between 1 and 8");
  end

  function automatic logic [4:0] wl_len(input logic [2:0] c);
    case (c)
      3'd0: wl_len = `MSP_WL_8;
      3'd1: wl_len = `MSP_WL_12;
      3'd2: wl_len = `MSP_WL_16;
      3'd3: wl_len = `MSP_WL_20;
      3'd4: wl_len = `MSP_WL_24;
      default: wl_len = `MSP_WL_32;
    endcase
  endfunction : wl_len

  // A channel is live when its block matches and its enable bit is set
  function automatic logic chan_on(input msp_chan_t ch, input msp_word_t en, input logic [1:0] b);
    chan_on = (ch[6:5] == b) && en[ch[4:0]];
  endfunction : chan_on

  logic [`MSP_CTL_W-1:0] ctl_ff;
  msp_word_t clk_ff, tch_ff, rch_ff, txdr_ff, rdr_ff, rbr_ff, xsr_ff, rsr_ff, prdata_ff;
  logic [`MSP_POL_W-1:0] pol_ff;
  logic [`MSP_STS_W-1:0] sts_ff, msk_ff;
  logic [`MSP_BLK_W-1:0] blk_ff;
  logic txdr_full_ff, rdr_full_ff, rbr_full_ff, pready_ff, pslverr_ff, irq_ff;
  logic tdma_ff, rdma_ff;
  logic [4:0] pin_s, prev_ff;
  logic [DIV_W-1:0] div_ff;
  logic gclk_ff, gfs_ff, tfs_seen_ff, rfs_seen_ff;
  logic [11:0] fcnt_ff;
  msp_seq_t tst_ff, rst_ff;
  logic [1:0] tdc_ff, rdc_ff;
  logic [4:0] tbit_ff, rbit_ff;
  msp_chan_t tchn_ff, rchn_ff;
  logic ton_ff, ron_ff, txd_ff, txoe_ff;
  logic tck_d_ff, tck_oe_ff, tfs_d_ff, tfs_oe_ff, rck_d_ff, rck_oe_ff, rfs_d_ff, rfs_oe_ff;
  logic [7:0] enc_code;
  logic [15:0] dec_lin;

  // APB decode; one wait state so that read data leaves a flip-flop
  wire acc = psel & penable;
  wire first = acc & ~pready_ff;
  wire wr = acc & pready_ff & pwrite;
  wire rd = acc & pready_ff & ~pwrite;
  wire hit_txd = paddr == `MSP_A_TXD;
  wire hit_rxd = paddr == `MSP_A_RXD;
  wire hit_ctl = paddr == `MSP_A_CTL;
  wire hit_clk = paddr == `MSP_A_CLK;
  wire hit_pol = paddr == `MSP_A_POL;
  wire hit_sts = paddr == `MSP_A_STS;
  wire hit_msk = paddr == `MSP_A_MSK;
  wire hit_sta = paddr == `MSP_A_STA;
  wire hit_tch = paddr == `MSP_A_TCH;
  wire hit_rch = paddr == `MSP_A_RCH;
  wire hit_blk = paddr == `MSP_A_BLK;
  wire mapped = |{hit_txd, hit_rxd, hit_ctl, hit_clk, hit_pol, hit_sts, hit_msk, hit_sta,
                  hit_tch, hit_rch, hit_blk};

  // Configuration fields
  wire tx_en = ctl_ff[`MSP_C_TXEN];
  wire rx_en = ctl_ff[`MSP_C_RXEN];
  wire tcmp = ctl_ff[`MSP_C_TCMP];
  wire rcmp = ctl_ff[`MSP_C_RCMP];
  wire lsbf = ctl_ff[`MSP_C_LSBF];
  wire tmc = ctl_ff[`MSP_C_TMC];
  wire rmc = ctl_ff[`MSP_C_RMC];
  wire stop = ctl_ff[`MSP_C_STOP];
  wire [1:0] tdly = ctl_ff[`MSP_C_TDLY];
  wire [1:0] rdly = ctl_ff[`MSP_C_RDLY];
  wire [4:0] tlen = tcmp ? `MSP_WL_8 : wl_len(ctl_ff[`MSP_C_TWL]);
  wire [4:0] rlen = rcmp ? `MSP_WL_8 : wl_len(ctl_ff[`MSP_C_RWL]);
  wire tci = stop ? ctl_ff[`MSP_C_SPIM] : clk_ff[`MSP_K_TCI];
  wire tfi = stop ? ctl_ff[`MSP_C_SPIM] : clk_ff[`MSP_K_TFI];
  wire tx_busy = tst_ff != SEQ_IDLE;
  wire rx_busy = rst_ff != SEQ_IDLE;

  wire [31:0] sta_val = 32'({rx_busy, tx_busy, rbr_full_ff, rdr_full_ff, txdr_full_ff});
  wire [31:0] rd_val = hit_txd ? txdr_ff : hit_rxd ? rdr_ff : hit_ctl ? 32'(ctl_ff) :
                       hit_clk ? clk_ff : hit_pol ? 32'(pol_ff) : hit_sts ? 32'(sts_ff) :
                       hit_msk ? 32'(msk_ff) : hit_sta ? sta_val : hit_tch ? tch_ff :
                       hit_rch ? rch_ff : hit_blk ? 32'(blk_ff) : 32'h00000000;

  // Pins from outside the clock domain
  msp_sync #(.W(5)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .raw({rx_serial_data, rx_frame_sync_pin, rx_bit_clock_pin, tx_frame_sync_pin,
          tx_bit_clock_pin}),
    .level(pin_s)
  );
  wire [4:0] x_rise = pin_s & ~prev_ff;
  wire [4:0] x_fall = ~pin_s & prev_ff;

  // Internal bit clock; toggling at most every cycle caps it at half of pclk
  wire div_hit = div_ff == DIV_W'(clk_ff[`MSP_K_DIV]);
  wire gen_run = ~stop | tx_busy | txdr_full_ff;
  wire g_tog = div_hit & (gen_run | gclk_ff);
  wire g_rise = g_tog & ~gclk_ff;
  wire g_fall = g_tog & gclk_ff;
  wire [11:0] fnext = (fcnt_ff == clk_ff[`MSP_K_PER]) ? 12'h000 : 12'(fcnt_ff + 12'h001);

  // Edge and frame sources, polarity applied per pin
  wire tx_lau = tci ? g_rise : (pol_ff[`MSP_P_TCK] ? x_fall[0] : x_rise[0]);
  wire tx_cap = tci ? g_fall : (pol_ff[`MSP_P_TCK] ? x_rise[0] : x_fall[0]);
  wire rc_cap = clk_ff[`MSP_K_RCI] ? g_fall : (pol_ff[`MSP_P_RCK] ? x_rise[2] : x_fall[2]);
  wire tfs = tfi ? gfs_ff : pin_s[1] ^ pol_ff[`MSP_P_TFS];
  wire rfs_p = clk_ff[`MSP_K_RFI] ? gfs_ff : pin_s[3] ^ pol_ff[`MSP_P_RFS];
  wire rx_cap = stop ? tx_cap : rc_cap;
  wire rfs = stop ? tfs : rfs_p;

  // Transmit sequencer
  wire t_start = tx_en & tx_lau & tfs & (stop ? ~tx_busy : ~tfs_seen_ff);
  wire t_dend = tx_lau & (tst_ff == SEQ_DELAY) & (tdc_ff == 2'd0);
  wire t_wend = tx_lau & (tst_ff == SEQ_SHIFT) & (tbit_ff == tlen);
  wire t_more = tmc & (tchn_ff != `MSP_CH_LAST);
  wire t_next = t_wend & t_more & ~t_start;
  wire t_begin = (t_start & (tdly == 2'd0)) | (t_dend & ~t_start) | t_next;
  wire [6:0] t_ch = t_next ? 7'(tchn_ff + 7'h01) : 7'h00;
  wire t_on = ~tmc | chan_on(t_ch, tch_ff, blk_ff[`MSP_B_TX]);
  wire t_load = t_begin & t_on & txdr_full_ff;
  wire t_und = t_begin & t_on & ~txdr_full_ff;
  wire [31:0] t_word = t_load ? (tcmp ? 32'(enc_code) : txdr_ff) : xsr_ff;
  wire t_step = t_begin | (tx_lau & (tst_ff == SEQ_SHIFT) & ~t_wend & ~t_start);
  wire [4:0] t_bit = t_begin ? 5'd0 : 5'(tbit_ff + 5'd1);
  wire [4:0] t_pos = lsbf ? t_bit : 5'(tlen - t_bit);
  wire t_quit = (t_wend & ~t_more) | t_start | ~tx_en;

  // Receive sequencer
  wire r_start = rx_en & rx_cap & rfs & (stop ? ~rx_busy : ~rfs_seen_ff);
  wire r_dend = rx_cap & (rst_ff == SEQ_DELAY) & (rdc_ff == 2'd0);
  wire r_wend = rx_cap & (rst_ff == SEQ_SHIFT) & (rbit_ff == rlen);
  wire r_more = rmc & (rchn_ff != `MSP_CH_LAST);
  wire r_next = r_wend & r_more & ~r_start;
  wire r_begin = (r_start & (rdly == 2'd0)) | (r_dend & ~r_start) | r_next;
  wire [6:0] r_ch = r_next ? 7'(rchn_ff + 7'h01) : 7'h00;
  wire r_on = ~rmc | chan_on(r_ch, rch_ff, blk_ff[`MSP_B_RX]);
  wire r_on_cur = r_begin ? r_on : ron_ff;
  wire r_step = r_begin | (rx_cap & (rst_ff == SEQ_SHIFT) & ~r_wend & ~r_start);
  wire [4:0] r_bit = r_begin ? 5'd0 : 5'(rbit_ff + 5'd1);
  wire [4:0] r_pos = lsbf ? r_bit : 5'(rlen - r_bit);
  wire [31:0] r_word = (r_begin ? 32'h00000000 : rsr_ff) | (32'(pin_s[4]) << r_pos);
  wire r_done = r_step & (r_bit == rlen) & r_on_cur;
  wire [31:0] r_val = rcmp ? {{16{dec_lin[15]}}, dec_lin} : r_word;

  // Buffer chain; a read and a refill in one cycle keep the new word
  wire rdr_rd = rd & hit_rxd;
  wire rbr_move = rbr_full_ff & (~rdr_full_ff | rdr_rd);
  wire r_accept = r_done & (~rbr_full_ff | rbr_move);
  wire r_ovr = r_done & ~r_accept;
  wire nxt_rdr_full = (rdr_full_ff & ~rdr_rd) | rbr_move;
  wire nxt_txdr_full = (txdr_full_ff & ~t_load) | (wr & hit_txd);

  // Sticky flags; an event in the clearing cycle survives
  wire [3:0] ev = {t_und, r_ovr, rbr_move, t_load};
  wire [3:0] w1c = (wr & hit_sts) ? pwdata[3:0] : 4'h0;
  wire [3:0] nxt_sts = (sts_ff & ~w1c) | ev;
  wire [3:0] nxt_msk = (wr & hit_msk) ? pwdata[3:0] : msk_ff;

  msp_compand u_comp (
    .enc_law(ctl_ff[`MSP_C_TLAW]),
    .lin(txdr_ff[15:0]),
    .code_out(enc_code),
    .dec_law(ctl_ff[`MSP_C_RLAW]),
    .code(r_word[7:0]),
    .lin_out(dec_lin)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= first;
      pslverr_ff <= first & ~mapped;
      if (first) prdata_ff <= pwrite ? 32'h00000000 : rd_val;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= `MSP_CTL_RST;
      clk_ff <= `MSP_CLK_RST;
      pol_ff <= '0;
      msk_ff <= '0;
      blk_ff <= '0;
      tch_ff <= 32'h00000000;
      rch_ff <= 32'h00000000;
      txdr_ff <= 32'h00000000;
    end else begin
      if (wr & hit_ctl) ctl_ff <= pwdata[`MSP_CTL_W-1:0];
      if (wr & hit_clk) clk_ff <= pwdata;
      if (wr & hit_pol) pol_ff <= pwdata[`MSP_POL_W-1:0];
      if (wr & hit_blk) blk_ff <= pwdata[`MSP_BLK_W-1:0];
      if (wr & hit_tch) tch_ff <= pwdata;
      if (wr & hit_rch) rch_ff <= pwdata;
      if (wr & hit_txd) txdr_ff <= pwdata;
      msk_ff <= nxt_msk;
    end
  end

  // Status, interrupt and DMA request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_ff <= '0;
      irq_ff <= 1'b0;
      tdma_ff <= 1'b0;
      rdma_ff <= 1'b0;
      txdr_full_ff <= 1'b0;
    end else begin
      sts_ff <= nxt_sts;
      irq_ff <= |(nxt_sts & nxt_msk);
      tdma_ff <= tx_en & ~nxt_txdr_full;
      rdma_ff <= nxt_rdr_full;
      txdr_full_ff <= nxt_txdr_full;
    end
  end

  // Clock and frame generator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= '0;
      gclk_ff <= 1'b0;
      fcnt_ff <= 12'h000;
      gfs_ff <= 1'b0;
      prev_ff <= '0;
    end else begin
      prev_ff <= pin_s;
      div_ff <= div_hit ? '0 : DIV_W'(div_ff + 1'b1);
      gclk_ff <= gclk_ff ^ g_tog;
      if (stop) gfs_ff <= tx_busy | txdr_full_ff;
      else if (g_rise) gfs_ff <= 12'(clk_ff[`MSP_K_WID]) >= fnext;
      if (g_rise) fcnt_ff <= fnext;
    end
  end

  // Transmitter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tst_ff <= SEQ_IDLE;
      tdc_ff <= 2'd0;
      tfs_seen_ff <= 1'b0;
    end else begin
      if (tx_lau) tfs_seen_ff <= tfs;
      if (!tx_en) tst_ff <= SEQ_IDLE;
      else if (t_start) tst_ff <= (tdly == 2'd0) ? SEQ_SHIFT : SEQ_DELAY;
      else if (t_dend) tst_ff <= SEQ_SHIFT;
      else if (t_wend & ~t_more) tst_ff <= SEQ_IDLE;
      if (t_start) tdc_ff <= 2'(tdly - 2'd1);
      else if (tx_lau & (tst_ff == SEQ_DELAY)) tdc_ff <= 2'(tdc_ff - 2'd1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tchn_ff <= '0;
      xsr_ff <= 32'h00000000;
      ton_ff <= 1'b0;
      tbit_ff <= 5'd0;
      txd_ff <= 1'b0;
      txoe_ff <= 1'b0;
    end else begin
      if (t_begin) begin
        tchn_ff <= t_ch;
        xsr_ff <= t_word;
        ton_ff <= t_on;
      end
      if (t_step) begin
        tbit_ff <= t_bit;
        txd_ff <= t_word[t_pos];
        txoe_ff <= t_begin ? t_on : ton_ff;
      end else if (t_quit) begin
        txoe_ff <= 1'b0;
      end
    end
  end

  // Receiver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_ff <= SEQ_IDLE;
      rdc_ff <= 2'd0;
      rfs_seen_ff <= 1'b0;
    end else begin
      if (rx_cap) rfs_seen_ff <= rfs;
      if (!rx_en) rst_ff <= SEQ_IDLE;
      else if (r_start) rst_ff <= (rdly == 2'd0) ? SEQ_SHIFT : SEQ_DELAY;
      else if (r_dend) rst_ff <= SEQ_SHIFT;
      else if (r_wend & ~r_more) rst_ff <= SEQ_IDLE;
      if (r_start) rdc_ff <= 2'(rdly - 2'd1);
      else if (rx_cap & (rst_ff == SEQ_DELAY)) rdc_ff <= 2'(rdc_ff - 2'd1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rchn_ff <= '0;
      ron_ff <= 1'b0;
      rbit_ff <= 5'd0;
      rsr_ff <= 32'h00000000;
      rbr_ff <= 32'h00000000;
      rbr_full_ff <= 1'b0;
      rdr_ff <= 32'h00000000;
      rdr_full_ff <= 1'b0;
    end else begin
      if (r_begin) begin
        rchn_ff <= r_ch;
        ron_ff <= r_on;
      end
      if (r_step) begin
        rbit_ff <= r_bit;
        rsr_ff <= r_word;
      end
      if (r_accept) rbr_ff <= r_val;
      rbr_full_ff <= (rbr_full_ff & ~rbr_move) | r_accept;
      if (rbr_move) rdr_ff <= rbr_ff;
      rdr_full_ff <= nxt_rdr_full;
    end
  end

  // Pin drivers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {tck_d_ff, tck_oe_ff, tfs_d_ff, tfs_oe_ff} <= 4'h0;
      {rck_d_ff, rck_oe_ff, rfs_d_ff, rfs_oe_ff} <= 4'h0;
    end else begin
      tck_d_ff <= gclk_ff ^ pol_ff[`MSP_P_TCK];
      tck_oe_ff <= tci;
      tfs_d_ff <= gfs_ff ^ pol_ff[`MSP_P_TFS];
      tfs_oe_ff <= tfi;
      rck_d_ff <= gclk_ff ^ pol_ff[`MSP_P_RCK];
      rck_oe_ff <= clk_ff[`MSP_K_RCI] & ~stop;
      rfs_d_ff <= gfs_ff ^ pol_ff[`MSP_P_RFS];
      rfs_oe_ff <= clk_ff[`MSP_K_RFI] & ~stop;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign tx_dma_req = tdma_ff;
  assign rx_dma_req = rdma_ff;
  assign tx_bit_clock_drv = tck_d_ff;
  assign tx_bit_clock_oe = tck_oe_ff;
  assign tx_frame_sync_drv = tfs_d_ff;
  assign tx_frame_sync_oe = tfs_oe_ff;
  assign tx_serial_data = txd_ff;
  assign tx_serial_data_oe = txoe_ff;
  assign rx_bit_clock_drv = rck_d_ff;
  assign rx_bit_clock_oe = rck_oe_ff;
  assign rx_frame_sync_drv = rfs_d_ff;
  assign rx_frame_sync_oe = rfs_oe_ff;
endmodule : msp_serial_port

// File: rtl/msp_map.svh
// Register map, field positions, reset values and coding constants of the serial port
`ifndef MSP_MAP_SVH
`define MSP_MAP_SVH
`define MSP_A_TXD 8'h00
`define MSP_A_RXD 8'h04
`define MSP_A_CTL 8'h08
`define MSP_A_CLK 8'h0c
`define MSP_A_POL 8'h10
`define MSP_A_STS 8'h14
`define MSP_A_MSK 8'h18
`define MSP_A_STA 8'h1c
`define MSP_A_TCH 8'h20
`define MSP_A_RCH 8'h24
`define MSP_A_BLK 8'h28
`define MSP_C_TXEN 0
`define MSP_C_RXEN 1
`define MSP_C_TWL 4:2
`define MSP_C_RWL 7:5
`define MSP_C_TDLY 9:8
`define MSP_C_RDLY 11:10
`define MSP_C_TCMP 12
`define MSP_C_TLAW 13
`define MSP_C_RCMP 14
`define MSP_C_RLAW 15
`define MSP_C_LSBF 16
`define MSP_C_TMC 17
`define MSP_C_RMC 18
`define MSP_C_STOP 19
`define MSP_C_SPIM 20
`define MSP_CTL_W 21
`define MSP_CTL_RST 21'h000000
`define MSP_K_DIV 7:0
`define MSP_K_PER 19:8
`define MSP_K_WID 27:20
`define MSP_K_TCI 28
`define MSP_K_TFI 29
`define MSP_K_RCI 30
`define MSP_K_RFI 31
`define MSP_CLK_RST 32'h00000000
`define MSP_P_TCK 0
`define MSP_P_RCK 1
`define MSP_P_TFS 2
`define MSP_P_RFS 3
`define MSP_POL_W 4
`define MSP_S_TXE 0
`define MSP_S_RXF 1
`define MSP_S_OVR 2
`define MSP_S_UND 3
`define MSP_STS_W 4
`define MSP_B_TX 1:0
`define MSP_B_RX 3:2
`define MSP_BLK_W 4
`define MSP_WL_8 5'd7
`define MSP_WL_12 5'd11
`define MSP_WL_16 5'd15
`define MSP_WL_20 5'd19
`define MSP_WL_24 5'd23
`define MSP_WL_32 5'd31
`define MSP_CH_LAST 7'h7f
`define MSP_MU_BIAS 16'h0084
`define MSP_MU_CLIP 16'h7f7b
`define MSP_A_MASK 8'h55
`define MSP_A_RND 4'h8
`define MSP_A_SEG 16'h0100
`endif

// File: rtl/msp_pkg.sv
// Types shared by the serial port modules
package msp_pkg;
  typedef logic [31:0] msp_word_t;
  typedef logic [6:0] msp_chan_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DELAY, SEQ_SHIFT} msp_seq_t;
endpackage : msp_pkg

// File: rtl/msp_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module msp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // Pins and filtered levels
  input logic [W-1:0] raw,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] lvl_ff;

  if (W < 1) begin : g_bad_w
    $error("msp_sync width must be at least 1");
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      lvl_ff <= '0;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff ^ s3_ff));
    end
  end

  assign level = lvl_ff;
endmodule : msp_sync

// File: rtl/msp_compand.sv
// Mu-law and A-law encoder and decoder
`timescale 1ns/100ps
`include "msp_map.svh"
module msp_compand (
  // Encoder
  input logic enc_law,
  input logic [15:0] lin,
  output logic [7:0] code_out,
  // Decoder
  input logic dec_law,
  input logic [7:0] code,
  output logic [15:0] lin_out
);
  logic [15:0] mag;
  logic [15:0] mb;
  logic [11:0] ab;
  logic [2:0] me;
  logic [2:0] ae;
  logic [3:0] mm;
  logic [3:0] am;
  logic [7:0] cu;
  logic [7:0] ca;
  logic [15:0] ut;
  logic [15:0] um;
  logic [15:0] at;

  // Clipping first keeps the most negative input from wrapping to zero
  always_comb begin
    mag = lin[15] ? 16'(-lin) : lin;
    if (mag > `MSP_MU_CLIP) mag = `MSP_MU_CLIP;
    mb = 16'(mag + `MSP_MU_BIAS);
    ab = mag[14:3];
    me = '0;
    ae = '0;
    for (int i = 1; i < 8; i++) begin
      if (mb[i + 7]) me = 3'(i);
      if (ab[i + 4]) ae = 3'(i);
    end
    mm = 4'(mb >> ({1'b0, me} + 4'd3));
    am = (ae == 3'd0) ? ab[4:1] : 4'(ab >> ae);
    code_out = enc_law ? ({~lin[15], ae, am} ^ `MSP_A_MASK) : ~{lin[15], me, mm};
  end

  always_comb begin
    cu = ~code;
    ca = code ^ `MSP_A_MASK;
    ut = 16'((16'({12'h000, cu[3:0]} << 3) + `MSP_MU_BIAS) << cu[6:4]);
    um = 16'(ut - `MSP_MU_BIAS);
    at = {8'h00, ca[3:0], `MSP_A_RND};
    if (ca[6:4] != 3'd0) at = 16'(16'(at + `MSP_A_SEG) << (ca[6:4] - 3'd1));
    if (dec_law) lin_out = ca[7] ? at : 16'(-at);
    else lin_out = cu[7] ? 16'(-um) : um;
  end
endmodule : msp_compand

// File: verification/msp_checker_properties.sv
// Port-level properties of the serial port, bound to its top module
`timescale 1ns/100ps
`include "msp_map.svh"
module msp_checker (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // APB
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input msp_pkg::msp_word_t prdata,
  input logic pready,
  input logic pslverr,
  // Events and pin enables
  input logic irq,
  input logic tx_dma_req,
  input logic rx_dma_req,
  input logic tx_bit_clock_oe,
  input logic tx_serial_data_oe
);
  import msp_pkg::*;
  logic wr_done;
  logic rd_rx;
  assign wr_done = psel && penable && pready && pwrite;
  assign rd_rx = psel && penable && pready && !pwrite && (paddr == `MSP_A_RXD);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_one_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_zero: assert property (pslverr |-> pready && prdata == '0)
    else $error("error response malformed");
  a_write_zero: assert property (pready && pwrite |-> prdata == '0)
    else $error("read data nonzero on write");
  a_reset_quiet: assert property ($rose(presetn) |-> !irq && !tx_dma_req && !rx_dma_req
    && !tx_serial_data_oe)
    else $error("outputs active right after reset");
  a_rx_dma_read: assert property ($fell(rx_dma_req) |->
    $past(rd_rx) || $past(rd_rx, 2) || $past(rd_rx, 3))
    else $error("receive request dropped without a read");
  a_tx_dma_write: assert property ($fell(tx_dma_req) |->
    $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
    else $error("transmit request dropped without a write");
  a_clk_oe_cfg: assert property ($rose(tx_bit_clock_oe) |->
    $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3))
    else $error("clock drive enabled without a write");
endmodule : msp_checker
bind msp_serial_port msp_checker u_msp_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req), .tx_bit_clock_oe(tx_bit_clock_oe),
  .tx_serial_data_oe(tx_serial_data_oe));

// File: verification/msp_codec_model.sv
// Behavioural serial codec facing the port's link pins
`timescale 1ns/100ps
module msp_codec_model (
  // Toward the port receiver
  output logic link_ck,
  output logic link_fs,
  output logic link_dat,
  // From the port transmitter
  input logic tx_ck,
  input logic tx_dat,
  input logic tx_dat_oe
);
  logic [31:0] sh;
  logic [31:0] q[$];
  initial begin
    link_ck = 1'b0;
    link_fs = 1'b0;
    link_dat = 1'b0;
    sh = '0;
  end
  // Clock stands still between frames; idle data toggles so stale bits never look valid
  task automatic send(input logic [31:0] w, input int len, input int hp);
    int b;
    #1.3;
    for (b = -1; b < len; b++) begin
      link_ck = 1'b1;
      link_fs = (b < 0);
      link_dat = (b < 0) ? ~link_dat : w[len-1-b];
      #(hp);
      link_ck = 1'b0;
      #(hp);
    end
    link_dat = ~link_dat;
  endtask : send
  always @(negedge tx_ck) begin
    if (tx_dat_oe) sh <= {sh[30:0], tx_dat};
  end
  always @(negedge tx_dat_oe) begin
    q.push_back(sh);
  end
endmodule : msp_codec_model

// File: verification/msp_serial_port_tb.sv
// Self-checking bench for the serial port
`timescale 1ns/100ps
`include "msp_map.svh"
module msp_serial_port_tb;
  import msp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, tx_dma_req, rx_dma_req;
  logic [7:0] paddr;
  msp_word_t pwdata, prdata, rdata;
  logic tx_ck_drv, tx_ck_oe, tx_fs_drv, tx_fs_oe, tx_dat_q, tx_dat_oe;
  logic rx_ck_drv, rx_ck_oe, rx_fs_drv, rx_fs_oe, link_ck, link_fs, link_dat, rerr;
  int err_count, n_checks, i, k;
  integer seed;
  msp_word_t w[3];
  logic [7:0] regs[5] = '{`MSP_A_CTL, `MSP_A_CLK, `MSP_A_POL, `MSP_A_STS, `MSP_A_MSK};
  // Undriven transmit pins are pulled low; undriven receive clock and frame sync follow the codec link
  wire tx_ck = tx_ck_oe ? tx_ck_drv : 1'b0;
  wire tx_fs = tx_fs_oe ? tx_fs_drv : 1'b0;
  wire tx_dat = tx_dat_oe ? tx_dat_q : 1'b0;
  wire rx_ck = rx_ck_oe ? rx_ck_drv : link_ck;
  wire rx_fs = rx_fs_oe ? rx_fs_drv : link_fs;
  msp_serial_port u_msp_serial_port (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req),
    .tx_bit_clock_pin(tx_ck), .tx_bit_clock_drv(tx_ck_drv), .tx_bit_clock_oe(tx_ck_oe),
    .tx_frame_sync_pin(tx_fs), .tx_frame_sync_drv(tx_fs_drv), .tx_frame_sync_oe(tx_fs_oe),
    .tx_serial_data(tx_dat_q), .tx_serial_data_oe(tx_dat_oe), .rx_bit_clock_pin(rx_ck),
    .rx_bit_clock_drv(rx_ck_drv), .rx_bit_clock_oe(rx_ck_oe), .rx_frame_sync_pin(rx_fs),
    .rx_frame_sync_drv(rx_fs_drv), .rx_frame_sync_oe(rx_fs_oe), .rx_serial_data(link_dat));
  msp_codec_model u_msp_codec_model (.link_ck(link_ck), .link_fs(link_fs),
    .link_dat(link_dat), .tx_ck(tx_ck), .tx_dat(tx_dat), .tx_dat_oe(tx_dat_oe));
  function automatic int wlen(input int c);
    return (c < 5) ? 8 + 4 * c : 32;
  endfunction : wlen
  function automatic msp_word_t rev(input msp_word_t v);
    for (int j = 0; j < 32; j++) rev[j] = v[31 - j];
    return rev;
  endfunction : rev
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One idle edge first, so no signal is assigned twice in one step
  task automatic apb(input logic wr, input logic [7:0] a, input msp_word_t d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #200000;
    err_count++;
    final_report();
  end
  initial begin
    seed = 32'hd69bc9e9;
    {err_count, n_checks, presetn, psel, penable, pwrite} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("quiet", {irq, tx_dma_req, rx_dma_req}, 0);
    for (k = 0; k < 5; k++) begin
      apb(1'b0, regs[k], '0);
      chk("reset_value", rdata, 0);
    end
    apb(1'b1, 8'h2c, 32'hffff_ffff);
    chk("unmapped_err", rerr, 1);
    chk("unmapped_data", rdata, 0);
    apb(1'b1, `MSP_A_CLK, 32'h3000_0f01);
    apb(1'b1, `MSP_A_MSK, 32'h2);
    chk("pin_oe", {tx_ck_oe, tx_fs_oe, rx_ck_oe, rx_fs_oe}, 4'hc);
    for (k = 0; k < 6; k++) begin
      apb(1'b1, `MSP_A_CTL, 32'h402 | (k << 5));
      for (i = 0; i < 2; i++) begin
        w[i] = msp_word_t'($random(seed) & ((64'h1 << wlen(k)) - 1));
        u_msp_codec_model.send(w[i], wlen(k), 24);
      end
      repeat (20) @(posedge pclk);
      chk("rx_irq", {irq, rx_dma_req}, 2'b11);
      apb(1'b1, `MSP_A_MSK, 32'h0);
      repeat (2) @(posedge pclk);
      chk("rx_irq_masked", irq, 0);
      apb(1'b1, `MSP_A_MSK, 32'h2);
      apb(1'b0, `MSP_A_RXD, '0);
      chk("rx_word0", rdata, w[0]);
      apb(1'b0, `MSP_A_RXD, '0);
      chk("rx_word1", rdata, w[1]);
      apb(1'b1, `MSP_A_STS, 32'hf);
      apb(1'b0, `MSP_A_STS, '0);
      chk("sts_clear", rdata | 32'(rx_dma_req), 0);
    end
    // Least significant bit first on receive: the codec still sends MSB first
    apb(1'b1, `MSP_A_CTL, 32'h104a2);
    for (i = 0; i < 3; i++) begin
      w[i] = $random(seed);
      u_msp_codec_model.send(w[i], 32, 24);
    end
    repeat (20) @(posedge pclk);
    apb(1'b0, `MSP_A_STS, '0);
    chk("rx_overrun", rdata[`MSP_S_OVR], 1);
    apb(1'b0, `MSP_A_RXD, '0);
    chk("ovr_word0", rdata, rev(w[0]));
    apb(1'b0, `MSP_A_RXD, '0);
    chk("ovr_word1", rdata, rev(w[1]));
    w[0] = $random(seed) & 32'hff;
    w[1] = $random(seed) & 32'hff;
    apb(1'b1, `MSP_A_TXD, w[0]);
    apb(1'b1, `MSP_A_CTL, 32'h503);
    for (i = 0; i < 500 && tx_dma_req !== 1'b1; i++) @(posedge pclk);
    chk("tx_dma", tx_dma_req, 1);
    apb(1'b1, `MSP_A_TXD, w[1]);
    repeat (400) @(posedge pclk);
    chk("tx_count", u_msp_codec_model.q.size() >= 3, 1);
    chk("tx_word0", u_msp_codec_model.q[0][7:0], w[0]);
    chk("tx_word1", u_msp_codec_model.q[1][7:0], w[1]);
    chk("tx_resend", u_msp_codec_model.q[2][7:0], w[1]);
    apb(1'b0, `MSP_A_STS, '0);
    chk("tx_flags", rdata[3:0] & 4'h9, 4'h9);
    final_report();
  end
endmodule : msp_serial_port_tb
